/* include/cor_pkg.sv */
/*
 * Shared constants and types for the codec output routing controls:
 * register offsets, field positions, reset values, bus states, and the
 * packed carriers between the register bank and the starved-DAC filler.
 * Assumes a 32-bit Avalon-MM slave port with byte addressing.
 */
// Contract
// [R1] With spread enable set, the spread selector lines for centre/LFE, surround and line out are driven.
// [R2] With spread enable clear (reset value), spreading happens only when jack sense turns it on.
// [R3] The jack sense input gates spreading through the jack-gated spread select field.
// [R4] Spread enable leaves the line out and headphone source selects untouched.
// [R5] While spreading is active the centre and LFE outputs are fed from the mono output path.
// [R6] Centre/LFE output disable clear keeps those outputs driven, set tri-states them.
// [R7] Down-mix select with upper bit clear (reset value) gives no down-mix unless jack sense asks.
// [R8] Down-mix select 10 sums centre and LFE equally into the mixer left and right.
// [R9] Down-mix select 11 also sums the surround channels into the mixer left and right.
// [R10] Surround output disable clear keeps the surround pins driven, set puts them in high impedance.
// [R11] The mute split flag is read-only and always reads 1.
// [R12] The vendor addressing flag is read-only and always reads 1.
// [R13] With DAC zero-fill clear, a starved DAC repeats its previous sample.
// [R14] With DAC zero-fill set, a starved DAC is fed zero samples.
// [R15] Software writes 0 to reserved bits and reserved bits read 0.
// [R16] New routing, down-mix or fill settings take effect at the next audio frame boundary.
package cor_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned COR_AW = 8;
    localparam logic [7:0] COR_OFS_CTRL = 8'h00;
    localparam logic [7:0] COR_OFS_JACK = 8'h04;
    localparam logic [7:0] COR_OFS_STAT = 8'h08;

    // Control register fields
    localparam int unsigned COR_B_SPREAD = 0;
    localparam int unsigned COR_B_CL_DIS = 1;
    localparam int unsigned COR_B_DOWNMIX_SELECT_LO = 2;
    localparam int unsigned COR_B_DOWNMIX_SELECT_HI = 3;
    localparam int unsigned COR_B_SURR_DIS = 4;
    localparam int unsigned COR_B_ZFILL = 5;
    localparam int unsigned COR_B_MSPLIT = 6;
    localparam int unsigned COR_B_VADDR = 7;
    localparam int unsigned COR_B_LINE_OUT_SOURCE_SELECT = 8;
    localparam int unsigned COR_B_HEADPHONE_SOURCE_SELECT_LO = 9;
    localparam int unsigned COR_B_HEADPHONE_SOURCE_SELECT_HI = 10;

    // Jack register fields
    localparam int unsigned COR_B_JSPREAD = 0;
    localparam int unsigned COR_B_JDMIX_LO = 1;
    localparam int unsigned COR_B_JDMIX_HI = 2;
    localparam int unsigned COR_B_JSTATE_LO = 8;
    localparam int unsigned COR_B_JSTATE_HI = 9;

    // Status register fields
    localparam int unsigned COR_B_S_SPREAD = 0;
    localparam int unsigned COR_B_S_DOWNMIX_SELECT_LO = 1;
    localparam int unsigned COR_B_S_DOWNMIX_SELECT_HI = 2;
    localparam int unsigned COR_B_S_CL_OE_B = 3;
    localparam int unsigned COR_B_S_SURR_OE_B = 4;
    localparam int unsigned COR_B_S_ZFILL = 5;
    localparam int unsigned COR_B_S_STARVED = 6;

    // Byte lanes that hold writable bits
    localparam int unsigned COR_LANE0 = 0;
    localparam int unsigned COR_LANE1 = 1;

    // Fixed read-only flag values
    localparam logic COR_MUTE_SPLIT_VAL = 1'b1;
    localparam logic COR_VEND_ADDR_VAL = 1'b1;

    // Down-mix codes; any code with upper bit clear means none
    localparam logic [1:0] COR_DOWNMIX_SELECT_NONE = 2'b00;
    localparam logic [1:0] COR_DOWNMIX_SELECT_6TO4 = 2'b10;
    localparam logic [1:0] COR_DOWNMIX_SELECT_6TO2 = 2'b11;
    localparam int unsigned COR_DOWNMIX_SELECT_ON = 1;

    // Jack sense input lanes
    localparam int unsigned COR_JS_W = 2;
    localparam int unsigned COR_JS_SPREAD = 0;
    localparam int unsigned COR_JS_DOWNMIX_SELECT = 1;

    // DAC frame geometry
    localparam int unsigned COR_NCH = 6;
    localparam int unsigned COR_SW = 20;
    localparam logic [COR_SW-1:0] COR_ZERO_SAMPLE = 20'h0_0000;

    localparam logic [31:0] COR_RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        COR_BUS_IDLE = 2'b01,
        COR_BUS_ACK = 2'b10
    } cor_bus_st_t;

    typedef struct packed {
        logic [1:0] hp_sel;
        logic line_sel;
        logic zero_fill;
        logic surr_dis;
        logic [1:0] downmix_select;
        logic cl_dis;
        logic spread;
    } cor_cfg_t;

    localparam cor_cfg_t COR_CFG_RST = '{hp_sel: 2'b00, line_sel: 1'b0, zero_fill: 1'b0,
        surr_dis: 1'b0, downmix_select: 2'b00, cl_dis: 1'b0, spread: 1'b0};

    typedef struct packed {
        logic [1:0] downmix_select_gate;
        logic spread_gate;
    } cor_jack_t;

    localparam cor_jack_t COR_JACK_RST = '{downmix_select_gate: 2'b00, spread_gate: 1'b0};

    typedef struct packed {
        logic spread_cl_sel;
        logic spread_surr_sel;
        logic spread_line_sel;
        logic cl_from_mono;
        logic mix_cl_lr;
        logic mix_surr_lr;
        logic cl_oe_b;
        logic surr_oe_b;
        logic line_sel;
        logic [1:0] hp_sel;
        logic [1:0] downmix_select_act;
    } cor_route_t;

    // Output enables are active low, so high means pins released; reset keeps them driven
    localparam cor_route_t COR_ROUTE_RST = '{spread_cl_sel: 1'b0, spread_surr_sel: 1'b0,
        spread_line_sel: 1'b0, cl_from_mono: 1'b0, mix_cl_lr: 1'b0, mix_surr_lr: 1'b0,
        cl_oe_b: 1'b0, surr_oe_b: 1'b0, line_sel: 1'b0, hp_sel: 2'b00, downmix_select_act: 2'b00};

    typedef logic [COR_NCH-1:0][COR_SW-1:0] cor_frame_t;

    typedef struct packed {
        cor_frame_t data;
        logic starved;
    } cor_dac_st_t;

    typedef struct packed {
        cor_bus_st_t st;
        logic waitreq;
        logic [31:0] rdata;
        cor_cfg_t cfg;
        cor_jack_t jcfg;
        cor_cfg_t live;
        cor_jack_t jlive;
        logic [COR_JS_W-1:0] js_m;
        logic [COR_JS_W-1:0] js_s;
        cor_route_t route;
    } cor_st_t;

endpackage : cor_pkg

/* verilog/cor_dac_fill.sv */
/*
 * Starved-DAC filler: once per audio frame, loads a fresh six-channel
 * sample set, or, when none is ready, repeats the last set or feeds zeros.
 * Assumes frame strobe, valid and data come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cor_dac_fill
    import cor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_frame,
    input wire logic i_dac_valid,
    input wire cor_frame_t i_dac_data,
    input wire logic i_zero_fill,
    output cor_frame_t o_dac_data,
    output logic o_starved
);

    cor_dac_st_t st_q;
    cor_dac_st_t st_d;

    // ------------------------------------------------------------------
    // Per-channel fill selection
    // ------------------------------------------------------------------
    cor_frame_t fill;

    genvar ch;
    generate
        for (ch = 0; ch < COR_NCH; ch++) begin : g_ch
            // Zero or repeat; fill mode is latched per frame by the parent
            assign fill[ch] = i_zero_fill ? COR_ZERO_SAMPLE : st_q.data[ch]; // [R13] [R14]
        end
    endgenerate

    // Next state only moves on a frame boundary, so no frame is torn
    always_comb begin
        st_d = st_q;
        if (i_frame) begin
            st_d.starved = !i_dac_valid;
            st_d.data = i_dac_valid ? i_dac_data : fill; // [R13] [R14]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_dac_data = st_q.data;
    assign o_starved = st_q.starved;

endmodule : cor_dac_fill

`default_nettype wire

/* verilog/cor_routing.sv */
/*
 * Codec output routing register bank: spread, down-mix, output tri-state,
 * read-only capability flags and DAC fill mode, reached over Avalon-MM
 * with waitrequest. Settings written by software land in a shadow copy
 * and are applied at the next audio frame strobe.
 * Assumes i_frame is a one-cycle pulse from same-clock link logic and
 * i_jack_sense comes from pins (synchronised here).
 */
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cor_routing
    import cor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Avalon-MM slave
    input wire logic [COR_AW-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Frame timing and jack sense pins
    input wire logic i_frame,
    input wire logic [COR_JS_W-1:0] i_jack_sense,
    // DAC sample path
    input wire logic i_dac_valid,
    input wire cor_frame_t i_dac_data,
    output cor_frame_t o_dac_data,
    // Analogue selector and pin controls
    output cor_route_t o_route
);

    cor_st_t q;
    cor_st_t d;

    logic starved;

    // ------------------------------------------------------------------
    // Register read image
    // ------------------------------------------------------------------
    logic [31:0] ctrl_img;
    logic [31:0] jack_img;
    logic [31:0] stat_img;
    logic [31:0] rd_img;
    logic addr_hit;

    // Unlisted bits stay zero so reserved fields read back as zero
    always_comb begin
        ctrl_img = COR_RD_ZERO; // [R15]
        ctrl_img[COR_B_SPREAD] = q.cfg.spread;
        ctrl_img[COR_B_CL_DIS] = q.cfg.cl_dis;
        ctrl_img[COR_B_DOWNMIX_SELECT_HI:COR_B_DOWNMIX_SELECT_LO] = q.cfg.downmix_select;
        ctrl_img[COR_B_SURR_DIS] = q.cfg.surr_dis;
        ctrl_img[COR_B_ZFILL] = q.cfg.zero_fill;
        ctrl_img[COR_B_MSPLIT] = COR_MUTE_SPLIT_VAL; // [R11]
        ctrl_img[COR_B_VADDR] = COR_VEND_ADDR_VAL; // [R12]
        ctrl_img[COR_B_LINE_OUT_SOURCE_SELECT] = q.cfg.line_sel;
        ctrl_img[COR_B_HEADPHONE_SOURCE_SELECT_HI:COR_B_HEADPHONE_SOURCE_SELECT_LO] = q.cfg.hp_sel;
    end

    // Jack image shows configured gating plus synchronised pin state
    always_comb begin
        jack_img = COR_RD_ZERO; // [R15]
        jack_img[COR_B_JSPREAD] = q.jcfg.spread_gate;
        jack_img[COR_B_JDMIX_HI:COR_B_JDMIX_LO] = q.jcfg.downmix_select_gate;
        jack_img[COR_B_JSTATE_HI:COR_B_JSTATE_LO] = q.js_s;
    end

    // Status image shows what is applied now, not what was written
    always_comb begin
        stat_img = COR_RD_ZERO;
        stat_img[COR_B_S_SPREAD] = q.route.spread_cl_sel;
        stat_img[COR_B_S_DOWNMIX_SELECT_HI:COR_B_S_DOWNMIX_SELECT_LO] = q.route.downmix_select_act;
        stat_img[COR_B_S_CL_OE_B] = q.route.cl_oe_b;
        stat_img[COR_B_S_SURR_OE_B] = q.route.surr_oe_b;
        stat_img[COR_B_S_ZFILL] = q.live.zero_fill;
        stat_img[COR_B_S_STARVED] = starved;
    end

    // Address decode; unmapped reads return zero, writes are dropped
    always_comb begin
        addr_hit = 1'b1;
        case (i_address)
            COR_OFS_CTRL: rd_img = ctrl_img;
            COR_OFS_JACK: rd_img = jack_img;
            COR_OFS_STAT: rd_img = stat_img;
            default: begin
                rd_img = COR_RD_ZERO;
                addr_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Effective routing from the live settings and jack state
    // ------------------------------------------------------------------
    logic spread_act;
    logic [1:0] downmix_select_act;
    cor_route_t route_n;

    // Software spread or a jack-gated spread; either one turns it on
    assign spread_act = d.live.spread // [R1] [R2]
        | (d.jlive.spread_gate & q.js_s[COR_JS_SPREAD]); // [R3]

    // Software code wins when its upper bit is set; else jack may select
    always_comb begin
        if (d.live.downmix_select[COR_DOWNMIX_SELECT_ON]) begin
            downmix_select_act = d.live.downmix_select; // [R8] [R9]
        end else if (q.js_s[COR_JS_DOWNMIX_SELECT] && d.jlive.downmix_select_gate[COR_DOWNMIX_SELECT_ON]) begin
            downmix_select_act = d.jlive.downmix_select_gate;
        end else begin
            downmix_select_act = COR_DOWNMIX_SELECT_NONE; // [R7]
        end
    end

    // Selector lines; line out and headphone selects bypass spreading
    always_comb begin
        route_n = COR_ROUTE_RST;
        route_n.spread_cl_sel = spread_act; // [R1]
        route_n.spread_surr_sel = spread_act; // [R1]
        route_n.spread_line_sel = spread_act; // [R1]
        route_n.cl_from_mono = spread_act; // [R5]
        route_n.mix_cl_lr = downmix_select_act[COR_DOWNMIX_SELECT_ON]; // [R8]
        route_n.mix_surr_lr = (downmix_select_act == COR_DOWNMIX_SELECT_6TO2); // [R9]
        route_n.cl_oe_b = d.live.cl_dis; // [R6]
        route_n.surr_oe_b = d.live.surr_dis; // [R10]
        route_n.line_sel = d.live.line_sel; // [R4]
        route_n.hp_sel = d.live.hp_sel; // [R4]
        route_n.downmix_select_act = downmix_select_act;
    end

    // ------------------------------------------------------------------
    // Next state: bus handshake, shadow writes, frame-aligned apply
    // ------------------------------------------------------------------
    logic req;
    logic commit;

    assign req = i_read | i_write;
    // Access completes at the edge where waitrequest is seen low
    assign commit = (q.st == COR_BUS_ACK) && req;

    always_comb begin
        d = q;
        // Jack pins: first stage only feeds the second
        d.js_m = i_jack_sense;
        d.js_s = q.js_m;

        // One wait cycle per access keeps read data a registered value
        case (q.st)
            COR_BUS_IDLE: begin
                if (req) begin
                    d.st = COR_BUS_ACK;
                    d.waitreq = 1'b0;
                    d.rdata = i_read ? rd_img : COR_RD_ZERO;
                end
            end
            COR_BUS_ACK: begin
                d.st = COR_BUS_IDLE;
                d.waitreq = 1'b1;
            end
            default: begin
                d.st = COR_BUS_IDLE;
                d.waitreq = 1'b1;
            end
        endcase

        // Writes only touch the shadow copy; read-only flags ignore writes
        if (commit && i_write && addr_hit) begin
            if (i_address == COR_OFS_CTRL) begin
                if (i_byteenable[COR_LANE0]) begin
                    d.cfg.spread = i_writedata[COR_B_SPREAD];
                    d.cfg.cl_dis = i_writedata[COR_B_CL_DIS]; // [R6]
                    d.cfg.downmix_select = i_writedata[COR_B_DOWNMIX_SELECT_HI:COR_B_DOWNMIX_SELECT_LO];
                    d.cfg.surr_dis = i_writedata[COR_B_SURR_DIS]; // [R10]
                    d.cfg.zero_fill = i_writedata[COR_B_ZFILL];
                end
                if (i_byteenable[COR_LANE1]) begin
                    d.cfg.line_sel = i_writedata[COR_B_LINE_OUT_SOURCE_SELECT];
                    d.cfg.hp_sel = i_writedata[COR_B_HEADPHONE_SOURCE_SELECT_HI:COR_B_HEADPHONE_SOURCE_SELECT_LO];
                end
            end else if (i_address == COR_OFS_JACK) begin
                if (i_byteenable[COR_LANE0]) begin
                    d.jcfg.spread_gate = i_writedata[COR_B_JSPREAD]; // [R3]
                    d.jcfg.downmix_select_gate = i_writedata[COR_B_JDMIX_HI:COR_B_JDMIX_LO];
                end
            end
        end

        // Shadow to live only at a frame strobe; a write landing on the
        // strobe edge waits for the following frame
        if (i_frame) begin
            d.live = q.cfg; // [R16]
            d.jlive = q.jcfg; // [R16]
        end

        // Route outputs registered; jack changes also step per frame
        if (i_frame) begin
            d.route = route_n; // [R16]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            q.st <= COR_BUS_IDLE;
            q.waitreq <= 1'b1;
            q.rdata <= COR_RD_ZERO;
            q.cfg <= COR_CFG_RST; // [R2] [R7]
            q.jcfg <= COR_JACK_RST;
            q.live <= COR_CFG_RST;
            q.jlive <= COR_JACK_RST;
            q.js_m <= '0;
            q.js_s <= '0;
            q.route <= COR_ROUTE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Starved-DAC filler, fill mode as applied at this very frame
    // ------------------------------------------------------------------
    cor_dac_fill u_fill (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_frame(i_frame),
        .i_dac_valid(i_dac_valid),
        .i_dac_data(i_dac_data),
        .i_zero_fill(d.live.zero_fill), // [R13] [R14]
        .o_dac_data(o_dac_data),
        .o_starved(starved)
    );

    // ------------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------------
    // Waitrequest is high except for the single completing cycle
    assign o_waitrequest = q.waitreq;
    assign o_readdata = q.rdata;
    assign o_route = q.route;

endmodule : cor_routing

`default_nettype wire

/* verification/cor_routing_chk.sv */
/*
 * Checker for the output routing register bank: bus answer timing, flag
 * and reserved bits, frame-bound updates of routing and DAC samples.
 * Assumes it is bound to cor_routing and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module cor_routing_chk
    import cor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [COR_AW-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic i_frame,
    input wire logic i_dac_valid,
    input wire cor_frame_t i_dac_data,
    input wire cor_frame_t o_dac_data,
    input wire cor_route_t o_route
);
    // ---------------------------------------------------------------
    // One clock domain, reset disables every check
    // ---------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Bus answers after exactly one wait cycle
    bus_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus answer late");
    // Route and DAC outputs move only on a frame edge
    route_hold_a: assert property (!i_frame |=> $stable(o_route))
        else $error("routing changed without frame");
    dac_hold_a: assert property (!i_frame |=> $stable(o_dac_data))
        else $error("dac data changed without frame");
    dac_load_a: assert property (i_frame && i_dac_valid |=>
        o_dac_data == $past(i_dac_data)) else $error("fresh samples not loaded");
    // Starved frame either repeats or zeroes, never anything else
    dac_starve_a: assert property (i_frame && !i_dac_valid |=>
        (o_dac_data == $past(o_dac_data)) || (o_dac_data == '0))
        else $error("starved frame gave odd samples");
    spread_tie_a: assert property (
        (o_route.cl_from_mono == o_route.spread_cl_sel) &&
        (o_route.spread_surr_sel == o_route.spread_cl_sel) &&
        (o_route.spread_line_sel == o_route.spread_cl_sel)) else $error("spread lines split");
    mix_code_a: assert property (
        (o_route.mix_cl_lr == o_route.downmix_select_act[1]) &&
        (o_route.mix_surr_lr == (o_route.downmix_select_act == 2'b11))) else $error("mix lines wrong");
    mix_none_a: assert property (!o_route.downmix_select_act[1] |-> o_route.downmix_select_act == 2'b00)
        else $error("down-mix code without upper bit");
    flag_read_a: assert property (
        i_read && o_waitrequest && i_address == COR_OFS_CTRL |=>
        o_readdata[7:6] == 2'b11 && o_readdata[31:11] == '0) else $error("flag bits wrong");
    unmapped_a: assert property (
        i_read && o_waitrequest && i_address != COR_OFS_CTRL &&
        i_address != COR_OFS_JACK && i_address != COR_OFS_STAT |=> o_readdata == '0)
        else $error("unmapped read not zero");
    // Status mirrors the live pin state when no frame intervenes
    status_mirror_a: assert property (
        i_read && o_waitrequest && i_address == COR_OFS_STAT && !i_frame |=>
        o_readdata[4:0] == {o_route.surr_oe_b, o_route.cl_oe_b,
        o_route.downmix_select_act, o_route.spread_cl_sel}) else $error("status mismatch");
endmodule : cor_routing_chk

bind cor_routing cor_routing_chk u_cor_routing_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_frame(i_frame), .i_dac_valid(i_dac_valid),
    .i_dac_data(i_dac_data), .o_dac_data(o_dac_data), .o_route(o_route));

`default_nettype wire

/* verification/cor_routing_bench.sv */
/*
 * Self-checking bench for the output routing register bank.
 * Assumes one 250 MHz clock; the bench plays Avalon master and frame source.
 */
`timescale 1ns/1ps
`default_nettype none

module cor_routing_bench
    import cor_pkg::*;
;
    logic i_clk, i_rst_b, i_read, i_write, i_frame, i_dac_valid, o_waitrequest;
    logic [7:0] i_address;
    logic [31:0] i_writedata, o_readdata;
    logic [3:0] i_byteenable;
    logic [1:0] i_jack_sense;
    cor_frame_t i_dac_data, o_dac_data;
    cor_route_t o_route;
    int fail_count, tests_run;

    cor_routing u_cor_routing (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_frame(i_frame), .i_jack_sense(i_jack_sense), .i_dac_valid(i_dac_valid),
        .i_dac_data(i_dac_data), .o_dac_data(o_dac_data), .o_route(o_route));

    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // One Avalon access; holds everything until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be, output logic [31:0] q);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        i_write <= wr;
        i_read <= !wr;
        // No local limit: a wait that never ends is left to the watchdog
        do begin
            @(posedge i_clk);
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk(128'(q), 128'(exp), msg);
    endtask : rd

    // One frame strobe; returns mid-cycle once outputs have settled
    task automatic frame(input logic v, input cor_frame_t d);
        @(posedge i_clk);
        i_frame <= 1'b1;
        i_dac_valid <= v;
        i_dac_data <= d;
        @(posedge i_clk);
        i_frame <= 1'b0;
        i_dac_valid <= 1'b0;
        @(negedge i_clk);
    endtask : frame

    function automatic cor_route_t er(input logic sp, input logic [1:0] dm, input logic cl,
            input logic su, input logic ls, input logic [1:0] hp);
        er = '{spread_cl_sel: sp, spread_surr_sel: sp, spread_line_sel: sp, cl_from_mono: sp,
            mix_cl_lr: dm[1], mix_surr_lr: dm == 2'b11, cl_oe_b: cl, surr_oe_b: su,
            line_sel: ls, hp_sel: hp, downmix_select_act: dm[1] ? dm : 2'b00};
    endfunction : er

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        chk(128'(o_route), 128'(er(0, 0, 0, 0, 0, 0)), "reset route");
        rd(COR_OFS_CTRL, 32'h0000_00C0, "ctrl reset");
        rd(COR_OFS_JACK, 32'h0000_0000, "jack reset");
        rd(8'h0C, 32'h0000_0000, "unmapped");
        // Every defined bit set; software keeps reserved bits at zero
        wr(COR_OFS_CTRL, 32'h0000_07FF, 4'hF);
        rd(COR_OFS_CTRL, 32'h0000_07FF, "ctrl all ones");
        wr(COR_OFS_CTRL, 32'h0000_0000, 4'h1);
        rd(COR_OFS_CTRL, 32'h0000_07C0, "lane0 only");
        wr(8'h0C, 32'h0000_FFFF, 4'hF);
        wr(COR_OFS_CTRL, 32'h0000_0000, 4'hF);
        rd(COR_OFS_CTRL, 32'h0000_00C0, "ctrl cleared");
    endtask : t_regs

    task automatic t_spread();
        wr(COR_OFS_CTRL, 32'h0000_0501, 4'hF);
        chk(128'(o_route), 128'(er(0, 0, 0, 0, 0, 0)), "no frame yet");
        frame(1'b1, '0);
        chk(128'(o_route), 128'(er(1, 0, 0, 0, 1, 2'b10)), "spread on");
        rd(COR_OFS_STAT, 32'h0000_0001, "status spread");
        wr(COR_OFS_CTRL, 32'h0000_0500, 4'hF);
        frame(1'b1, '0);
        chk(128'(o_route), 128'(er(0, 0, 0, 0, 1, 2'b10)), "spread off");
    endtask : t_spread

    task automatic t_downmix_select();
        logic [1:0] c;
        cor_route_t e;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(COR_OFS_CTRL, {27'h0, c[1], c, c[0], 1'b0}, 4'hF);
            frame(1'b1, '0);
            e = er(0, c, c[0], c[1], 0, 0);
            chk(128'(o_route), 128'(e), "mix and tri-state");
        end
        wr(COR_OFS_CTRL, 32'h0000_0000, 4'hF);
        frame(1'b1, '0);
    endtask : t_downmix_select

    task automatic t_jack();
        wr(COR_OFS_JACK, 32'h0000_0005, 4'hF);
        i_jack_sense <= 2'b11;
        repeat (4) @(posedge i_clk);
        frame(1'b1, '0);
        chk(128'(o_route), 128'(er(1, 2'b10, 0, 0, 0, 0)), "jack gated");
        rd(COR_OFS_JACK, 32'h0000_0305, "jack state");
        i_jack_sense <= 2'b00;
        repeat (4) @(posedge i_clk);
        frame(1'b1, '0);
        chk(128'(o_route), 128'(er(0, 0, 0, 0, 0, 0)), "jack removed");
    endtask : t_jack

    task automatic t_fill();
        cor_frame_t a, b;
        a = {6{20'h1_2345}};
        b = {6{20'hA_5A5A}};
        frame(1'b1, a);
        chk(128'(o_dac_data), 128'(a), "load a");
        frame(1'b0, b);
        chk(128'(o_dac_data), 128'(a), "repeat a");
        wr(COR_OFS_CTRL, 32'h0000_0020, 4'hF);
        chk(128'(o_dac_data), 128'(a), "fill waits");
        frame(1'b0, b);
        chk(128'(o_dac_data), 128'(0), "zero fill");
        rd(COR_OFS_STAT, 32'h0000_0060, "status starved");
        frame(1'b1, b);
        chk(128'(o_dac_data), 128'(b), "load b");
    endtask : t_fill

    // ---------------------------------------------------------------
    // Clock, run and verdict
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Whole run is well under two hundred cycles; this limit leaves ample margin
    initial begin
        repeat (5000) @(posedge i_clk);
        fail_count++;
        test_done();
    end

    initial begin
        {i_rst_b, i_read, i_write, i_frame, i_dac_valid} = '0;
        i_address = '0;
        i_writedata = '0;
        i_byteenable = '0;
        i_jack_sense = '0;
        i_dac_data = '0;
        fail_count = 0;
        tests_run = 0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(negedge i_clk);
        t_regs();
        t_spread();
        t_downmix_select();
        t_jack();
        t_fill();
        test_done();
    end
endmodule : cor_routing_bench

`default_nettype wire
